// *** hw/mssel_pkg.sv ***
// Purpose: constants and types for the multi-speed frequency selector
// Assumes: frequencies are held in units of 0.1 Hz
// Notes: Operation
// Operation
// - high, middle, low select run their presets
// - three presets reset 50/30/10 Hz, 0-400 Hz
// - several of high/middle/low, combined speed unset: lowest speed wins
// - speeds 4-15 chosen by four select combinations
// - speeds 4-15 reset to not-selected, else 0-400
// - extra only, speed 8 unset: run low
// - jog, multi-speed, analog 2, analog 1 ranking
// - multi-speed honoured only in modes 3, 4
// - presets 1-3 writable anytime; all presets ignore write selection
// - no priority between 4-7 and 8-15 groups
// - remote selection nonzero turns selects into remote
// - selects routed by terminal function codes 0-2
// - extra select from terminal with code 8
// - speeds 4-15 writable only when extended display 0
package mssel_pkg;
  localparam logic [15:0] FREQ_MAX = 16'h0fa0;
  localparam logic [15:0] NOT_SEL = 16'h270f;
  localparam logic [15:0] HIGH_RST = 16'h01f4;
  localparam logic [15:0] MID_RST = 16'h012c;
  localparam logic [15:0] LOW_RST = 16'h0064;
  localparam logic [3:0] IDX_HIGH = 4'h1;
  localparam logic [3:0] IDX_MID = 4'h2;
  localparam logic [3:0] IDX_LOW = 4'h3;
  localparam logic [3:0] IDX_FIRST_EXT = 4'h4;
  localparam logic [3:0] IDX_SPEED8 = 4'h8;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_TMAP = 12'h004;
  localparam logic [11:0] REG_STAT = 12'h008;
  localparam logic [11:0] REG_PRESET = 12'h040;
  localparam int CTRL_OPM_LSB = 0;
  localparam int CTRL_RFS_LSB = 4;
  localparam int CTRL_PWS_LSB = 8;
  localparam int CTRL_EXT_LSB = 12;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [3:0] OPM_EXT = 4'h3;
  localparam logic [3:0] OPM_COMB = 4'h4;
  localparam int NUM_TERM = 5;
  localparam int FUNC_W = 6;
  localparam logic [31:0] TMAP_RST = 32'h3ffc2040;
  localparam logic [5:0] FUNC_LOW = 6'h00;
  localparam logic [5:0] FUNC_MID = 6'h01;
  localparam logic [5:0] FUNC_HIGH = 6'h02;
  localparam logic [5:0] FUNC_EXTRA = 6'h08;
  localparam int STAT_SRC_LSB = 16;
  localparam int STAT_IDX_LSB = 20;
  typedef struct packed {
    logic extra;
    logic high;
    logic middle;
    logic low;
  } mssel_sel_t;
  typedef enum logic [1:0] {
    SRC_AIN1 = 2'b00,
    SRC_AIN2 = 2'b01,
    SRC_MS = 2'b10,
    SRC_JOG = 2'b11
  } mssel_src_t;
  typedef struct packed {
    mssel_src_t src;
    logic [15:0] freq;
  } mssel_cmd_t;
endpackage

// *** hw/mssel_route.sv ***
// Purpose: route terminal levels to the four speed selects
// Assumes: terminal levels are synchronous to the clock
// Notes: several terminals with one code are ORed together
`timescale 1ns/1ps
module mssel_route import mssel_pkg::*; #(
  parameter int NT = NUM_TERM
) (
  input wire logic [NT-1:0] term_in, // terminal levels, high = on
  input wire logic [NT*FUNC_W-1:0] term_func, // function code per terminal
  output mssel_sel_t sel // routed selects
);
  always_comb begin
    sel = '0;
    for (int i = 0; i < NT; i++) begin
      if (term_in[i]) begin
        case (term_func[i*FUNC_W +: FUNC_W])
          FUNC_LOW: sel.low = 1'b1;
          FUNC_MID: sel.middle = 1'b1;
          FUNC_HIGH: sel.high = 1'b1;
          FUNC_EXTRA: sel.extra = 1'b1;
          default: begin
          end
        endcase
      end
    end
  end
endmodule

// *** hw/mssel_decode.sv ***
// Purpose: map a select combination to a speed number
// Assumes: speed 0 means nothing is selected
// Notes: fb_idx is the three-speed choice used when a preset is unset
`timescale 1ns/1ps
module mssel_decode import mssel_pkg::*; (
  input mssel_sel_t sel, // routed selects
  output logic [3:0] idx, // addressed speed number
  output logic [3:0] fb_idx // lowest-signal fallback speed
);
  always_comb begin
    // each combination addresses one preset, no group ranking
    case ({sel.extra, sel.high, sel.middle, sel.low})
      4'b0001: idx = IDX_LOW;
      4'b0010: idx = IDX_MID;
      4'b0100: idx = IDX_HIGH;
      4'b0011: idx = 4'h4;
      4'b0101: idx = 4'h5;
      4'b0110: idx = 4'h6;
      4'b0111: idx = 4'h7;
      4'b1000: idx = IDX_SPEED8;
      4'b1001: idx = 4'h9;
      4'b1010: idx = 4'ha;
      4'b1100: idx = 4'hb;
      4'b1011: idx = 4'hc;
      4'b1101: idx = 4'hd;
      4'b1110: idx = 4'he;
      4'b1111: idx = 4'hf;
      default: idx = 4'h0;
    endcase
    if (sel.low) begin
      fb_idx = IDX_LOW;
    end else if (sel.middle) begin
      fb_idx = IDX_MID;
    end else if (sel.high) begin
      fb_idx = IDX_HIGH;
    end else if (sel.extra) begin
      fb_idx = IDX_LOW;
    end else begin
      fb_idx = 4'h0;
    end
  end
endmodule

// *** hw/mssel_top.sv ***
// Purpose: multi-speed frequency command selector with APB registers
// Assumes: APB master per the AMBA protocol, one clock, synchronous reset
// Notes: frequencies in 0.1 Hz units; command updates one cycle after inputs
`timescale 1ns/1ps
module mssel_top import mssel_pkg::*; #(
  parameter int NT = NUM_TERM
) (
  input wire logic clock, // 50 MHz system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [11:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [NT-1:0] term_in, // contact terminal levels
  input wire logic jog_on, // jog operation active
  input wire logic [15:0] jog_freq, // jog frequency
  input wire logic [15:0] ain2_freq, // second analog input frequency
  input wire logic ain2_valid, // second analog input in use
  input wire logic [15:0] ain1_freq, // first analog input frequency
  output mssel_cmd_t freq_cmd, // selected running frequency and source
  output logic [3:0] speed_idx, // speed preset in use, 0 if none
  output logic remote_accel, // remote-setting accelerate
  output logic remote_decel, // remote-setting decelerate
  output logic remote_clear // remote-setting clear
);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_preset(input logic [11:0] a);
    return a[11:6] == REG_PRESET[11:6] && a[5:2] != 4'h0;
  endfunction

  // multi-speed counts only in the two external modes with remote setting off
  function automatic logic ms_mode_ok(input logic [3:0] m, input logic [2:0] r);
    return (m == OPM_EXT || m == OPM_COMB) && r == 3'b000;
  endfunction

  // 9999 is legal only for speeds 4-15, where it parks the speed as unused
  function automatic logic in_range(input logic [15:0] v, input logic ext);
    return v <= FREQ_MAX || (ext && v == NOT_SEL);
  endfunction

  logic [31:0] ctrl;
  logic [31:0] tmap;
  logic [15:0] preset [1:15];
  logic [31:0] next_ctrl;
  logic [31:0] next_tmap;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic wr_en;
  logic [3:0] wr_idx;
  logic [15:0] wr_val;
  mssel_cmd_t next_cmd;
  logic [3:0] next_speed_idx;
  logic next_accel;
  logic next_decel;
  logic next_clear;
  mssel_sel_t sel;
  logic [3:0] comb_idx;
  logic [3:0] fb_idx;
  logic [3:0] opm;
  logic [2:0] rfs;
  logic [3:0] ext_disp;
  logic ms_ok;

  assign opm = ctrl[CTRL_OPM_LSB +: 4];
  assign rfs = ctrl[CTRL_RFS_LSB +: 3];
  assign ext_disp = ctrl[CTRL_EXT_LSB +: 4];
  // no wait states: read data is registered in the setup cycle
  assign pready = 1'b1;

  mssel_route #(.NT(NT)) u_route (
    .term_in(term_in),
    .term_func(tmap[NT*FUNC_W-1:0]),
    .sel(sel)
  );

  mssel_decode u_decode (
    .sel(sel),
    .idx(comb_idx),
    .fb_idx(fb_idx)
  );

  // register access
  always_comb begin
    logic [31:0] wv;
    logic [3:0] pi;
    wv = '0;
    pi = paddr[5:2];
    next_ctrl = ctrl;
    next_tmap = tmap;
    next_prdata = prdata;
    next_pslverr = pslverr;
    wr_en = 1'b0;
    wr_idx = pi;
    wr_val = '0;
    if (psel && !penable) begin
      next_prdata = '0;
      next_pslverr = 1'b0;
      if (is_preset(paddr)) begin
        wv = merge({16'h0000, preset[pi]}, pwdata, pstrb);
        if (!pwrite) begin
          next_prdata = {16'h0000, preset[pi]};
        end else if (pi >= IDX_FIRST_EXT && ext_disp != 4'h0) begin
          next_pslverr = 1'b1;
        end else if (!in_range(wv[15:0], pi >= IDX_FIRST_EXT)) begin
          next_pslverr = 1'b1;
        end
      end else if (paddr == REG_CTRL) begin
        next_prdata = ctrl;
      end else if (paddr == REG_TMAP) begin
        next_prdata = tmap;
      end else if (paddr == REG_STAT) begin
        next_prdata = {8'h00, speed_idx, 2'b00, freq_cmd};
        next_pslverr = pwrite;
      end else begin
        next_pslverr = 1'b1;
      end
    end else if (psel && penable && pwrite && !pslverr) begin
      if (is_preset(paddr)) begin
        wv = merge({16'h0000, preset[pi]}, pwdata, pstrb);
        // parameter write selection is not consulted for presets
        wr_en = 1'b1;
        wr_val = wv[15:0];
      end else if (paddr == REG_CTRL) begin
        next_ctrl = merge(ctrl, pwdata, pstrb);
      end else if (paddr == REG_TMAP) begin
        next_tmap = merge(tmap, pwdata, pstrb);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl <= CTRL_RST;
      tmap <= TMAP_RST;
      prdata <= '0;
      pslverr <= 1'b0;
      preset[IDX_HIGH] <= HIGH_RST;
      preset[IDX_MID] <= MID_RST;
      preset[IDX_LOW] <= LOW_RST;
      for (int i = 4; i < 16; i++) begin
        preset[i] <= NOT_SEL;
      end
    end else begin
      ctrl <= next_ctrl;
      tmap <= next_tmap;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      if (wr_en) begin
        preset[wr_idx] <= wr_val;
      end
    end
  end

  // frequency source selection
  always_comb begin
    logic [3:0] use_idx;
    use_idx = comb_idx;
    // an unset combined preset falls back to the lowest active signal
    if (comb_idx != 4'h0 && preset[comb_idx] == NOT_SEL) begin
      use_idx = fb_idx;
    end
    ms_ok = ms_mode_ok(opm, rfs) && use_idx != 4'h0;
    next_speed_idx = 4'h0;
    if (jog_on) begin
      next_cmd = '{src: SRC_JOG, freq: jog_freq};
    end else if (ms_ok) begin
      next_cmd = '{src: SRC_MS, freq: preset[use_idx]};
      next_speed_idx = use_idx;
    end else if (ain2_valid) begin
      next_cmd = '{src: SRC_AIN2, freq: ain2_freq};
    end else begin
      next_cmd = '{src: SRC_AIN1, freq: ain1_freq};
    end
    // with remote setting on, the selects drive the remote functions
    next_accel = (rfs != 3'b000) && sel.high;
    next_decel = (rfs != 3'b000) && sel.middle;
    next_clear = (rfs != 3'b000) && sel.low;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      freq_cmd <= '{src: SRC_AIN1, freq: 16'h0000};
      speed_idx <= 4'h0;
      remote_accel <= 1'b0;
      remote_decel <= 1'b0;
      remote_clear <= 1'b0;
    end else begin
      freq_cmd <= next_cmd;
      speed_idx <= next_speed_idx;
      remote_accel <= next_accel;
      remote_decel <= next_decel;
      remote_clear <= next_clear;
    end
  end

  logic ms_mode;
  logic wr_preset;
  assign ms_mode = ms_mode_ok(opm, rfs) && !jog_on;
  assign wr_preset = psel && penable && pwrite && is_preset(paddr);

  a_jog_wins: assert property (@(posedge clock) disable iff (sys_rst)
    jog_on |=> freq_cmd.src == SRC_JOG && freq_cmd.freq == $past(jog_freq))
    else $error("jog did not take the command");
  a_mode_gate: assert property (@(posedge clock) disable iff (sys_rst)
    !(opm == OPM_EXT || opm == OPM_COMB) |=> freq_cmd.src != SRC_MS)
    else $error("multi-speed used outside modes 3 and 4");
  a_remote_off: assert property (@(posedge clock) disable iff (sys_rst)
    rfs != 3'b000 |=> freq_cmd.src != SRC_MS && remote_accel == $past(sel.high))
    else $error("remote setting did not take the selects");
  a_high_run: assert property (@(posedge clock) disable iff (sys_rst)
    ms_mode && sel == 4'b0100 |=> freq_cmd.freq == $past(preset[IDX_HIGH]) && speed_idx == IDX_HIGH)
    else $error("high select did not run the high preset");
  a_low_wins: assert property (@(posedge clock) disable iff (sys_rst)
    ms_mode && sel == 4'b0110 && preset[4'h6] == NOT_SEL |=> freq_cmd.freq == $past(preset[IDX_MID]))
    else $error("middle did not win over high");
  a_extra_fall: assert property (@(posedge clock) disable iff (sys_rst)
    ms_mode && sel == 4'b1000 && preset[IDX_SPEED8] == NOT_SEL |=> speed_idx == IDX_LOW)
    else $error("extra alone did not fall back to low");
  a_ext_lock: assert property (@(posedge clock) disable iff (sys_rst)
    wr_preset && paddr[5:2] >= IDX_FIRST_EXT && ext_disp != 4'h0 |=> preset[$past(paddr[5:2])] == $past(preset[paddr[5:2]]))
    else $error("locked preset was written");
  a_write_any: assert property (@(posedge clock) disable iff (sys_rst)
    wr_preset && !pslverr && pstrb == 4'hf |=> preset[$past(paddr[5:2])] == $past(pwdata[15:0]))
    else $error("preset write did not land");
  // source ranking and command path
  a_ms_over_ain: assert property (@(posedge clock) disable iff (sys_rst)
    !jog_on && ms_ok |=> freq_cmd.src == SRC_MS)
    else $error("multi-speed did not rank over analog");
  a_ain2_rank: assert property (@(posedge clock) disable iff (sys_rst)
    !jog_on && !ms_ok && ain2_valid |=> freq_cmd.src == SRC_AIN2 && freq_cmd.freq == $past(ain2_freq))
    else $error("second analog input not taken");
  a_ain1_last: assert property (@(posedge clock) disable iff (sys_rst)
    !jog_on && !ms_ok && !ain2_valid |=> freq_cmd.src == SRC_AIN1 && freq_cmd.freq == $past(ain1_freq))
    else $error("first analog input not taken");
  a_jog_idx: assert property (@(posedge clock) disable iff (sys_rst)
    jog_on |=> speed_idx == 4'h0)
    else $error("speed number shown during jog");
  a_idx_quiet: assert property (@(posedge clock) disable iff (sys_rst)
    freq_cmd.src != SRC_MS |-> speed_idx == 4'h0)
    else $error("speed number shown without multi-speed");
  a_low_run: assert property (@(posedge clock) disable iff (sys_rst)
    ms_mode && sel == 4'b0001 |=> freq_cmd.freq == $past(preset[IDX_LOW]) && speed_idx == IDX_LOW)
    else $error("low select did not run the low preset");
  a_mid_run: assert property (@(posedge clock) disable iff (sys_rst)
    ms_mode && sel == 4'b0010 |=> freq_cmd.freq == $past(preset[IDX_MID]) && speed_idx == IDX_MID)
    else $error("middle select did not run the middle preset");
  a_combo_run: assert property (@(posedge clock) disable iff (sys_rst)
    ms_mode && comb_idx >= IDX_FIRST_EXT && preset[comb_idx] != NOT_SEL
    |=> speed_idx == $past(comb_idx) && freq_cmd.freq == $past(preset[comb_idx]))
    else $error("set speed preset not run");
  a_extra_set: assert property (@(posedge clock) disable iff (sys_rst)
    ms_mode && sel == 4'b1000 && preset[IDX_SPEED8] != NOT_SEL |=> speed_idx == IDX_SPEED8)
    else $error("extra alone did not run speed 8");
  a_never_unset: assert property (@(posedge clock) disable iff (sys_rst)
    freq_cmd.src == SRC_MS |-> freq_cmd.freq != NOT_SEL)
    else $error("unset preset reached the command");
  a_remote_quiet: assert property (@(posedge clock) disable iff (sys_rst)
    rfs == 3'b000 |=> !remote_accel && !remote_decel && !remote_clear)
    else $error("remote output without remote setting");
  a_remote_map: assert property (@(posedge clock) disable iff (sys_rst)
    rfs != 3'b000 |=> remote_decel == $past(sel.middle) && remote_clear == $past(sel.low))
    else $error("remote decelerate or clear not following selects");
  // register side refusals, acceptances and reset values
  a_ext_range: assert property (@(posedge clock) disable iff (sys_rst)
    psel && !penable && pwrite && is_preset(paddr) && paddr[5:2] >= IDX_FIRST_EXT && pstrb == 4'hf
    && pwdata[15:0] > FREQ_MAX && pwdata[15:0] != NOT_SEL |=> pslverr)
    else $error("out of range speed preset accepted");
  a_sentinel_ok: assert property (@(posedge clock) disable iff (sys_rst)
    psel && !penable && pwrite && is_preset(paddr) && paddr[5:2] >= IDX_FIRST_EXT && ext_disp == 4'h0
    && pstrb == 4'hf && pwdata[15:0] == NOT_SEL |=> !pslverr)
    else $error("not-selected value refused");
  a_high_sentinel: assert property (@(posedge clock) disable iff (sys_rst)
    psel && !penable && pwrite && is_preset(paddr) && paddr[5:2] < IDX_FIRST_EXT && pstrb == 4'hf
    && pwdata[15:0] == NOT_SEL |=> pslverr)
    else $error("not-selected value taken by a three-speed preset");
  a_ext_free: assert property (@(posedge clock) disable iff (sys_rst)
    psel && !penable && pwrite && is_preset(paddr) && paddr[5:2] >= IDX_FIRST_EXT && ext_disp == 4'h0
    && pstrb == 4'hf && pwdata[15:0] <= FREQ_MAX |=> !pslverr)
    else $error("unlocked speed preset refused");
  a_range_rej: assert property (@(posedge clock) disable iff (sys_rst)
    psel && !penable && pwrite && paddr == REG_PRESET + 12'h004 && pstrb == 4'hf && pwdata[15:0] > FREQ_MAX
    |=> pslverr)
    else $error("out of range preset accepted");
  a_reset_val: assert property (@(posedge clock) $fell(sys_rst) |-> preset[4'h9] == NOT_SEL && preset[IDX_MID] == MID_RST)
    else $error("preset reset values wrong");
  c_ms_run: cover property (@(posedge clock) disable iff (sys_rst) freq_cmd.src == SRC_MS);
  c_speed15: cover property (@(posedge clock) disable iff (sys_rst) speed_idx == 4'hf);
  c_remote: cover property (@(posedge clock) disable iff (sys_rst) remote_accel);
  c_slverr: cover property (@(posedge clock) disable iff (sys_rst) psel && penable && pslverr);
  c_ain2: cover property (@(posedge clock) disable iff (sys_rst) freq_cmd.src == SRC_AIN2);
endmodule

// *** dv/mssel_switch.sv ***
// Purpose: contact switch model that closes the speed select contacts
// Assumes: middle and high stay on terminals 1 and 2, low and extra are movable
// Notes: an open contact reads low; levels change only just after a rising edge
`timescale 1ns/1ps
module mssel_switch import mssel_pkg::*; (
  input wire logic clock, // system clock
  input wire mssel_sel_t want, // contacts to close
  input wire logic [2:0] low_at, // terminal wired to the low select
  input wire logic [2:0] extra_at, // terminal wired to the extra select
  output logic [NUM_TERM-1:0] term_in // terminal levels
);
  logic [NUM_TERM-1:0] next_term_in;
  always_comb begin
    next_term_in = '0;
    next_term_in[low_at] = want.low;
    next_term_in[1] = want.middle;
    next_term_in[2] = want.high;
    next_term_in[extra_at] = want.extra;
  end
  // registered so the selector sees contacts one edge late, like a real input stage
  always_ff @(posedge clock) begin
    term_in <= next_term_in;
  end
endmodule

// *** dv/multi_speed_frequency_selector_tb.sv ***
// Purpose: self-checking bench for the multi-speed frequency selector
// Assumes: apb slave answers without wait states but the master never relies on it
// Notes: command checks wait two edges, one for the switch model and one for the selector
`timescale 1ns/1ps
module multi_speed_frequency_selector_tb import mssel_pkg::*;;
  localparam logic [15:0] AIN1 = 16'h0111;
  localparam logic [15:0] AIN2 = 16'h0222;
  localparam logic [15:0] JOG = 16'h0032;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic jog_on = 1'b0;
  logic ain2_valid = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, remote_accel, remote_decel, remote_clear;
  logic [NUM_TERM-1:0] term_in;
  logic [3:0] speed_idx;
  logic [3:0] want = 4'h0;
  logic [2:0] low_at = 3'h0;
  logic [2:0] extra_at = 3'h3;
  mssel_cmd_t freq_cmd;
  int checked = 0;
  int n_mismatch = 0;
  logic [3:0] combo [12] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc, 4'hb, 4'hd, 4'he, 4'hf};

  mssel_switch sw_u (.clock(clock), .want(want), .low_at(low_at), .extra_at(extra_at), .term_in(term_in));
  mssel_top dut_u (.clock(clock), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_in(term_in), .jog_on(jog_on), .jog_freq(JOG), .ain2_freq(AIN2), .ain2_valid(ain2_valid),
    .ain1_freq(AIN1), .freq_cmd(freq_cmd), .speed_idx(speed_idx), .remote_accel(remote_accel),
    .remote_decel(remote_decel), .remote_clear(remote_clear));

  initial begin
    forever #10 clock = ~clock;
  end

  task automatic conclude();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic eerr);
    logic [31:0] rd;
    logic err;
    apb(a, 1'b1, d, rd, err);
    chk({31'h0, err}, {31'h0, eerr});
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(a, 1'b0, 32'h0, rd, err);
    chk({31'h0, err}, 32'h0);
    chk(rd, exp);
  endtask

  function automatic logic [11:0] pa(input int n);
    return REG_PRESET + 12'(4 * n);
  endfunction

  task automatic ctl(input logic [3:0] opm, input logic [2:0] rfs, input logic [3:0] ext);
    wr(REG_CTRL, (32'(ext) << CTRL_EXT_LSB) | (32'(rfs) << CTRL_RFS_LSB) | 32'(opm), 1'b0);
  endtask

  // the selector registers once and the switch once, so two edges settle a change
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic drive(input logic [3:0] s);
    @(posedge clock);
    want <= s;
    settle();
  endtask

  task automatic look(input logic [3:0] s, input mssel_src_t es, input logic [15:0] ef, input logic [3:0] ei);
    drive(s);
    chk({10'h0, freq_cmd, speed_idx}, {10'h0, es, ef, ei});
  endtask

  task automatic t_reset();
    rdchk(REG_CTRL, CTRL_RST);
    rdchk(REG_TMAP, TMAP_RST);
    rdchk(pa(1), {16'h0, HIGH_RST});
    rdchk(pa(2), {16'h0, MID_RST});
    rdchk(pa(3), {16'h0, LOW_RST});
    for (int n = 4; n < 16; n++) rdchk(pa(n), {16'h0, NOT_SEL});
    wr(pa(0), 32'h0, 1'b1);
    wr(REG_STAT, 32'h0, 1'b1);
  endtask

  task automatic t_three();
    ctl(OPM_EXT, 3'h0, 4'h0);
    look(4'b0100, SRC_MS, HIGH_RST, IDX_HIGH);
    look(4'b0010, SRC_MS, MID_RST, IDX_MID);
    look(4'b0001, SRC_MS, LOW_RST, IDX_LOW);
    look(4'b0110, SRC_MS, MID_RST, IDX_MID);
    look(4'b0111, SRC_MS, LOW_RST, IDX_LOW);
    for (int o = 0; o < 6; o++) begin
      ctl(4'(o), 3'h0, 4'h0);
      settle();
      if (o == 3 || o == 4) chk({10'h0, freq_cmd, speed_idx}, {10'h0, SRC_MS, LOW_RST, IDX_LOW});
      else chk({10'h0, freq_cmd, speed_idx}, {10'h0, SRC_AIN1, AIN1, 4'h0});
    end
    ctl(OPM_EXT, 3'h0, 4'h0);
  endtask

  task automatic t_extra();
    wr(REG_TMAP, 32'h3f202040, 1'b0);
    look(4'b1000, SRC_MS, LOW_RST, IDX_LOW);
    for (int k = 0; k < 12; k++) begin
      wr(pa(k + 4), {16'h0, 16'h0104 + 16'(k)}, 1'b0);
      look(combo[k], SRC_MS, 16'h0104 + 16'(k), 4'(k + 4));
    end
  endtask

  task automatic t_refuse();
    wr(pa(1), {16'h0, FREQ_MAX + 16'h1}, 1'b1);
    wr(pa(1), {16'h0, NOT_SEL}, 1'b1);
    rdchk(pa(1), {16'h0, HIGH_RST});
    wr(pa(4), {16'h0, FREQ_MAX + 16'h1}, 1'b1);
    look(4'b0100, SRC_MS, HIGH_RST, IDX_HIGH);
    wr(pa(1), {16'h0, FREQ_MAX}, 1'b0);
    settle();
    chk({10'h0, freq_cmd, speed_idx}, {10'h0, SRC_MS, FREQ_MAX, IDX_HIGH});
    ctl(OPM_EXT, 3'h0, 4'h1);
    wr(pa(5), 32'h0, 1'b1);
    wr(pa(2), 32'h0, 1'b0);
    rdchk(pa(5), 32'h0105);
    ctl(OPM_EXT, 3'h0, 4'h0);
    wr(pa(5), {16'h0, NOT_SEL}, 1'b0);
    look(4'b0101, SRC_MS, LOW_RST, IDX_LOW);
    rdchk(REG_STAT, {8'h0, IDX_LOW, 2'b00, SRC_MS, LOW_RST});
  endtask

  task automatic t_remote();
    ctl(OPM_EXT, 3'h1, 4'h0);
    for (int i = 0; i < 3; i++) begin
      look(4'(4 >> i), SRC_AIN1, AIN1, 4'h0);
      chk({29'h0, remote_accel, remote_decel, remote_clear}, 32'(4 >> i));
    end
    ctl(OPM_EXT, 3'h0, 4'h0);
  endtask

  task automatic srcchk(input logic j, input logic a2, input logic [3:0] s, input mssel_src_t es,
                        input logic [15:0] ef);
    @(posedge clock);
    jog_on <= j;
    ain2_valid <= a2;
    drive(s);
    chk({14'h0, freq_cmd}, {14'h0, es, ef});
  endtask

  task automatic t_source();
    srcchk(1'b1, 1'b1, 4'b0001, SRC_JOG, JOG);
    srcchk(1'b0, 1'b1, 4'b0001, SRC_MS, LOW_RST);
    srcchk(1'b0, 1'b1, 4'b0000, SRC_AIN2, AIN2);
    srcchk(1'b0, 1'b0, 4'b0000, SRC_AIN1, AIN1);
  endtask

  task automatic t_remap();
    wr(REG_TMAP, 32'h0020207f, 1'b0);
    @(posedge clock);
    low_at <= 3'h4;
    look(4'b0001, SRC_MS, LOW_RST, IDX_LOW);
  endtask

  // a second reset in mid-run must bring back presets 1, 2 and 9 and the map
  task automatic t_rerun();
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rdchk(pa(1), {16'h0, HIGH_RST});
    rdchk(pa(2), {16'h0, MID_RST});
    rdchk(pa(9), {16'h0, NOT_SEL});
    rdchk(REG_TMAP, TMAP_RST);
    chk({14'h0, freq_cmd}, {14'h0, SRC_AIN1, AIN1});
  endtask

  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_three();
    t_extra();
    t_refuse();
    t_remote();
    t_source();
    t_remap();
    t_rerun();
    conclude();
  end
endmodule
